// File: src/sfrpg_top.sv
// sfr paging, page select and xram page register
// Notes on behaviour
// - 8-bit indirect external move takes high address byte from xram page.
// - xram page bits 7:1 read zero and ignore writes.
// - xram page lives at 0xAA on page 0x0, resets to zero.
// - direct accesses 0x80..0xFF go to sfr space, not internal ram.
// - addresses ending 0x0 or 0x8 allow bit access; others byte only.
// - after reset all sfr accesses target page 0x0.
// - core registers decode on both pages, page select included.
// - page 0x0F decodes its own set on reused addresses.
// - 8-bit page select at 0xA7 on every page, resets zero.
// - 8-bit external move takes low byte from R0 or R1.
// - 16-bit external move uses full data pointer, ignores xram page.
`timescale 1ns/10ps
`default_nettype none
`include "sfrpg_cfg.svh"
module sfrpg_top (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst_n,
  // direct access from the core
  input  wire sfrpg_pkg::sfrpg_acc_type acc,
  input  wire logic                  acc_direct,
  // external move request
  input  wire logic                  xmove_req,
  input  wire logic                  xmove_short,
  input  wire logic                  xmove_sel_r1,
  input  wire logic [7:0]            idx_r0,
  input  wire logic [7:0]            idx_r1,
  input  wire logic [15:0]           data_pointer,
  // routing results
  output logic                       sfr_sel_q,
  output logic                       iram_sel_q,
  output logic [1:0]                 sfr_kind_q,
  output logic [7:0]                 sfr_page_q,
  output logic                       bit_err_q,
  output logic [7:0]                 rdata_q,
  output logic                       rdata_hit_q,
  output logic [15:0]                xaddr_q,
  output logic                       xaddr_vld_q,
  output logic                       xram_page_bit_q
);
  logic [7:0] sfr_page_select_q;
  logic [7:0] sfr_page_select_d;
  logic       xram_page_bit_d;
  sfrpg_pkg::sfrpg_dec_type kind;
  logic       bit_ok;

  sfrpg_decode u_dec (
    .addr   (acc.addr),
    .page   (sfr_page_select_q),
    .kind   (kind),
    .bit_ok (bit_ok)
  );

  wire is_sfr   = acc_direct && acc.addr[7];
  wire any_acc  = acc.wr || acc.rd;
  wire hit_page = is_sfr && acc.addr == `SFRPG_ADDR_PAGE_SEL;
  wire hit_xpg  = is_sfr && kind == sfrpg_pkg::SFRPG_DEC_MAIN
                  && acc.addr == `SFRPG_ADDR_XRAM_PAGE;
  wire bit_bad  = is_sfr && acc.bit_op && !bit_ok;
  wire [7:0] xpg_byte = {7'h00, xram_page_bit_q};

  // page_wr merges one bit on bit writes, but bit_bad blocks them at 0xA7 (byte only); the xram page bit keeps its value
  wire [7:0] bit_mask = 8'h01 << acc.bit_idx;
  wire [7:0] page_wr  = acc.bit_op
    ? ((sfr_page_select_q & ~bit_mask) | (acc.wdata[0] ? bit_mask : 8'h00))
    : acc.wdata;
  wire xpg_wr = acc.bit_op ? xram_page_bit_q : acc.wdata[`SFRPG_XRAM_PAGE_BIT];

  assign sfr_page_select_d = (hit_page && acc.wr && !bit_bad)
                             ? page_wr : sfr_page_select_q;
  assign xram_page_bit_d   = (hit_xpg && acc.wr && !bit_bad)
                             ? xpg_wr : xram_page_bit_q;

  wire [7:0] rd_mux = hit_page ? sfr_page_select_q
                    : hit_xpg  ? xpg_byte : 8'h00;

  // high byte from xram page on short form, full pointer on long form
  wire [7:0]  low_idx = xmove_sel_r1 ? idx_r1 : idx_r0;
  wire [15:0] xaddr_d = xmove_short ? {xpg_byte, low_idx}
                                    : data_pointer;

  // page select resets to page 0x0
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_page_select_q <= `SFRPG_PAGE_SEL_RESET;
      xram_page_bit_q   <= 1'(`SFRPG_XRAM_PAGE_RESET);
    end else begin
      sfr_page_select_q <= sfr_page_select_d;
      xram_page_bit_q   <= xram_page_bit_d;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      sfr_sel_q   <= 1'b0;
      iram_sel_q  <= 1'b0;
      sfr_kind_q  <= 2'h0;
      bit_err_q   <= 1'b0;
      rdata_q     <= 8'h00;
      rdata_hit_q <= 1'b0;
    end else begin
      sfr_sel_q   <= is_sfr && any_acc;
      iram_sel_q  <= !is_sfr && any_acc;
      sfr_kind_q  <= is_sfr ? kind : sfrpg_pkg::SFRPG_DEC_NONE;
      bit_err_q   <= bit_bad && any_acc;
      rdata_q     <= acc.rd ? rd_mux : 8'h00;
      rdata_hit_q <= acc.rd && (hit_page || hit_xpg);
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      xaddr_q     <= 16'h0000;
      xaddr_vld_q <= 1'b0;
    end else begin
      xaddr_q     <= xmove_req ? xaddr_d : xaddr_q;
      xaddr_vld_q <= xmove_req;
    end
  end

  assign sfr_page_q = sfr_page_select_q;

  // checks
  a_xpage_high: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    xmove_req && xmove_short |=> xaddr_q[15:9] == 7'h00
      && xaddr_q[8] == $past(xram_page_bit_q))
    else $error("short move high byte wrong");
  a_xpage_read: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    rdata_hit_q && $past(hit_xpg) |-> rdata_q[7:1] == 7'h00)
    else $error("xram page upper bits not zero");
  a_xpage_page: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    is_sfr && acc.addr == `SFRPG_ADDR_XRAM_PAGE
      |-> hit_xpg == (sfr_page_select_q == `SFRPG_PAGE_MAIN))
    else $error("xram page decode does not follow page 0");
  a_route_sfr: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    acc_direct && acc.addr[7] && acc.rd |=> sfr_sel_q && !iram_sel_q)
    else $error("direct upper access not routed to sfr");
  a_bit_col: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    is_sfr && acc.bit_op && acc.rd && acc.addr[2:0] != 3'h0
      |=> bit_err_q)
    else $error("bit access allowed on byte-only address");
  a_page_shared: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    is_sfr && acc.addr == 8'hE0 |-> kind == sfrpg_pkg::SFRPG_DEC_SHARED)
    else $error("shared register not shared");
  a_alt_page: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    is_sfr && acc.addr == 8'hB9 && sfr_page_select_q == `SFRPG_PAGE_ALT
      |-> kind == sfrpg_pkg::SFRPG_DEC_ALT)
    else $error("alt page decode missing");
  a_page_write: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    hit_page && acc.wr && !acc.bit_op |=> sfr_page_q == $past(acc.wdata))
    else $error("page select write lost");
  a_long_move: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    xmove_req && !xmove_short |=> xaddr_q == $past(data_pointer))
    else $error("long move address wrong");
  a_other_page: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    is_sfr && sfr_page_select_q != `SFRPG_PAGE_MAIN
      && sfr_page_select_q != `SFRPG_PAGE_ALT
      |-> kind != sfrpg_pkg::SFRPG_DEC_MAIN
      && kind != sfrpg_pkg::SFRPG_DEC_ALT)
    else $error("page-specific register on unknown page");
  c_alt_sel: cover property (@(posedge sys_clk) disable iff (!rst_n)
    hit_page && acc.wr && acc.wdata == `SFRPG_PAGE_ALT);
  c_short: cover property (@(posedge sys_clk) disable iff (!rst_n)
    xmove_req && xmove_short && xram_page_bit_q);
  c_xpg_wr: cover property (@(posedge sys_clk) disable iff (!rst_n)
    hit_xpg && acc.wr);
endmodule // sfrpg_top
`default_nettype wire

// File: src/sfrpg_cfg.svh
// sfr paging and xram page constants
`ifndef SFRPG_CFG_SVH
`define SFRPG_CFG_SVH
`define SFRPG_ADDR_PAGE_SEL   8'hA7
`define SFRPG_ADDR_XRAM_PAGE  8'hAA
`define SFRPG_PAGE_SEL_RESET  8'h00
`define SFRPG_XRAM_PAGE_RESET 8'h00
`define SFRPG_PAGE_MAIN       8'h00
`define SFRPG_PAGE_ALT        8'h0F
`define SFRPG_SFR_BASE        8'h80
`define SFRPG_XRAM_PAGE_BIT   0
`endif

// File: src/sfrpg_pkg.sv
// types for the sfr paging block
package sfrpg_pkg;
  typedef enum logic [1:0] {
    SFRPG_DEC_NONE,
    SFRPG_DEC_SHARED,
    SFRPG_DEC_MAIN,
    SFRPG_DEC_ALT
  } sfrpg_dec_type;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic       bit_op;
    logic [2:0] bit_idx;
    logic [7:0] wdata;
  } sfrpg_acc_type;
endpackage

// File: src/sfrpg_decode.sv
// page-aware sfr address decoder
`timescale 1ns/10ps
`default_nettype none
`include "sfrpg_cfg.svh"
module sfrpg_decode (
  // address and page
  input  wire logic [7:0]             addr,
  input  wire logic [7:0]             page,
  // decode result
  output var sfrpg_pkg::sfrpg_dec_type   kind,
  output logic                        bit_ok
);
  wire [3:0] row = addr[7:4];
  wire [3:0] col = addr[3:0];
  logic shared_hit;
  logic main_hit;
  logic alt_hit;

  // registers present on both pages
  always_comb begin
    case (addr)
      8'h80, 8'h81, 8'h82, 8'h83, 8'h87, 8'h90, 8'hA0, 8'hA7,
      8'hA8, 8'hA9, 8'hD0, 8'hE0, 8'hE5, 8'hE6, 8'hE7, 8'hF0,
      8'hF6, 8'hF7: shared_hit = 1'b1;
      default: shared_hit = 1'b0;
    endcase
  end

  // page 0x0F set reuses main addresses
  always_comb begin
    case (addr)
      8'h85, 8'h86, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96,
      8'h97, 8'hA4, 8'hA5, 8'hA6, 8'hB5, 8'hB9, 8'hBA, 8'hBD:
        alt_hit = 1'b1;
      default: alt_hit = 1'b0;
    endcase
  end

  // holes on the main page are reserved
  always_comb begin
    case (addr)
      8'hF3, 8'hD6, 8'hB4, 8'hAB, 8'hAF: main_hit = 1'b0;
      default: main_hit = 1'b1;
    endcase
  end

  // other page values leave only shared registers
  always_comb begin
    if (addr < `SFRPG_SFR_BASE) begin
      kind = sfrpg_pkg::SFRPG_DEC_NONE;
    end else if (shared_hit) begin
      kind = sfrpg_pkg::SFRPG_DEC_SHARED;
    end else if (page == `SFRPG_PAGE_MAIN && main_hit) begin
      kind = sfrpg_pkg::SFRPG_DEC_MAIN;
    end else if (page == `SFRPG_PAGE_ALT && alt_hit) begin
      kind = sfrpg_pkg::SFRPG_DEC_ALT;
    end else begin
      kind = sfrpg_pkg::SFRPG_DEC_NONE;
    end
  end

  // bit access only at column 0 or 8
  assign bit_ok = (col == 4'h0 || col == 4'h8) && row[3];
endmodule // sfrpg_decode
`default_nettype wire

// File: testbench/sfrpg_core_model.sv
// core-side model that issues sfr accesses and external moves
`timescale 1ns/10ps
`default_nettype none
module sfrpg_core_model (
  // clock
  input  wire logic                     sys_clk,
  // requests to the block
  output var sfrpg_pkg::sfrpg_acc_type   acc,
  output logic                          acc_direct,
  output logic                          xmove_req,
  output logic                          xmove_short,
  output logic                          xmove_sel_r1,
  output logic [7:0]                    idx_r0,
  output logic [7:0]                    idx_r1,
  output logic [15:0]                   data_pointer
);
  // idle lines carry inverted values so a stale request never looks live
  task automatic idle(input logic [7:0] a, input logic [7:0] d);
    acc = '{~a, 1'b0, 1'b0, 1'b0, 3'h0, ~d};
    xmove_req = 1'b0;
  endtask
  // any address can be requested, including unoccupied ones such as 0xB9 on page 0x05
  task automatic access(input logic [7:0] a, input logic dir, input logic w,
                        input logic bo, input logic [7:0] d);
    @(negedge sys_clk);
    acc = '{a, w, ~w, bo, 3'h0, d};
    acc_direct = dir;
    @(negedge sys_clk);
    idle(a, d);
  endtask
  task automatic xmove(input logic s, input logic s1, input logic [15:0] dp);
    @(negedge sys_clk);
    xmove_req = 1'b1;
    xmove_short = s;
    xmove_sel_r1 = s1;
    data_pointer = dp;
    @(negedge sys_clk);
    xmove_req = 1'b0;
  endtask
  initial begin
    idle(8'h00, 8'h00);
    acc_direct = 1'b1;
    xmove_short = 1'b0;
    xmove_sel_r1 = 1'b0;
    idx_r0 = 8'h34;
    idx_r1 = 8'h56;
    data_pointer = 16'h0000;
  end
endmodule // sfrpg_core_model
`default_nettype wire

// File: testbench/tb_top.sv
// self-checking bench for sfr paging and the xram page register
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic                     sys_clk, rst_n, acc_direct, xmove_req;
  logic                     xmove_short, xmove_sel_r1, sfr_sel_q, iram_sel_q;
  logic                     bit_err_q, rdata_hit_q, xaddr_vld_q;
  logic                     xram_page_bit_q;
  logic [1:0]               sfr_kind_q;
  logic [7:0]               idx_r0, idx_r1, sfr_page_q, rdata_q;
  logic [15:0]              data_pointer, xaddr_q;
  sfrpg_pkg::sfrpg_acc_type acc;
  int                       failures, n_checks;
  logic [7:0]               pg [3] = '{8'h00, 8'h0F, 8'h05};
  logic [15:0]              kb9 [3] = '{16'h2, 16'h3, 16'h0};
  sfrpg_top sfrpg_top_inst (.sys_clk(sys_clk), .rst_n(rst_n), .acc(acc),
    .acc_direct(acc_direct), .xmove_req(xmove_req), .xmove_short(xmove_short),
    .xmove_sel_r1(xmove_sel_r1), .idx_r0(idx_r0), .idx_r1(idx_r1),
    .data_pointer(data_pointer), .sfr_sel_q(sfr_sel_q),
    .iram_sel_q(iram_sel_q), .sfr_kind_q(sfr_kind_q), .sfr_page_q(sfr_page_q),
    .bit_err_q(bit_err_q), .rdata_q(rdata_q), .rdata_hit_q(rdata_hit_q),
    .xaddr_q(xaddr_q), .xaddr_vld_q(xaddr_vld_q),
    .xram_page_bit_q(xram_page_bit_q));
  sfrpg_core_model sfrpg_core_model_inst (.sys_clk(sys_clk), .acc(acc),
    .acc_direct(acc_direct), .xmove_req(xmove_req), .xmove_short(xmove_short),
    .xmove_sel_r1(xmove_sel_r1), .idx_r0(idx_r0), .idx_r1(idx_r1),
    .data_pointer(data_pointer));
  task automatic chk(input string nm, input logic [15:0] e,
                     input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic acs(input logic [7:0] a, input logic w, input logic [7:0] d);
    sfrpg_core_model_inst.access(a, 1'b1, w, 1'b0, d);
  endtask
  task automatic xm(input logic s, input logic s1, input logic [15:0] e);
    sfrpg_core_model_inst.xmove(s, s1, 16'h1234);
    chk("xaddr", e, xaddr_q);
    chk("xvld", 16'h1, 16'(xaddr_vld_q));
  endtask
  task automatic end_sim;
    if (failures == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    repeat (12) @(posedge sys_clk);
    @(negedge sys_clk);
    rst_n = 1'b1;
    chk("page", 16'h0, 16'(sfr_page_q));
    chk("xbit", 16'h0, 16'(xram_page_bit_q));
    acs(8'hA7, 1'b0, 8'h00);
    chk("rd_page", 16'h0, 16'(rdata_q));
    chk("kind_a7", 16'h1, 16'(sfr_kind_q));
    acs(8'hAA, 1'b1, 8'hFF);
    acs(8'hAA, 1'b0, 8'h00);
    chk("xpage", 16'h1, 16'(rdata_q));
    xm(1'b1, 1'b0, 16'h0134);
    xm(1'b1, 1'b1, 16'h0156);
    xm(1'b0, 1'b0, 16'h1234);
    acs(8'hAA, 1'b1, 8'h00);
    chk("xvld_off", 16'h0, 16'(xaddr_vld_q));
    chk("xhold", 16'h1234, xaddr_q);
    xm(1'b1, 1'b0, 16'h0034);
    // page 0x0, page 0xF, then an unused page
    for (int i = 0; i < 3; i++) begin
      acs(8'hA7, 1'b1, pg[i]);
      chk("page", 16'(pg[i]), 16'(sfr_page_q));
      acs(8'hB9, 1'b0, 8'h00);
      chk("kind_b9", kb9[i], 16'(sfr_kind_q));
      acs(8'hE0, 1'b0, 8'h00);
      chk("kind_e0", 16'h1, 16'(sfr_kind_q));
      acs(8'hAA, 1'b0, 8'h00);
      chk("hit_aa", 16'(i == 0), 16'(rdata_hit_q));
    end
    acs(8'hA7, 1'b1, 8'h00);
    sfrpg_core_model_inst.access(8'h90, 1'b1, 1'b0, 1'b0, 8'h00);
    chk("sfr_sel", 16'h1, 16'(sfr_sel_q));
    sfrpg_core_model_inst.access(8'h90, 1'b0, 1'b0, 1'b0, 8'h00);
    chk("iram_sel", 16'h1, 16'(iram_sel_q));
    sfrpg_core_model_inst.access(8'hA9, 1'b1, 1'b0, 1'b1, 8'h00);
    chk("bit_err", 16'h1, 16'(bit_err_q));
    sfrpg_core_model_inst.access(8'hA8, 1'b1, 1'b0, 1'b1, 8'h00);
    chk("bit_ok", 16'h0, 16'(bit_err_q));
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
